// ---- hdl/dch_cfg.svh ----
// Addresses, field positions, reset values and timing counts of the discrete channel block.
`ifndef DCH_CFG_SVH
`define DCH_CFG_SVH
`define DCH_CLK_HZ 20000000
`define DCH_US_CYC(us) ((us) * (`DCH_CLK_HZ / 1000000))
`define DCH_OFF_CTRL0 12'h000
`define DCH_OFF_CTRL1 12'h004
`define DCH_OFF_STATUS 12'h008
`define DCH_OFF_SAMPLE 12'h00C
`define DCH_OFF_SCALE 12'h010
`define DCH_OFF_GAIN 12'h014
`define DCH_OFF_OFFSET 12'h018
`define DCH_OFF_UNIT 12'h01C
`define DCH_OFF_VALUE0 12'h020
`define DCH_OFF_VALUE1 12'h024
`define DCH_F_INPOL 0
`define DCH_F_OUTHIGH 2
`define DCH_F_OTYPE 3
`define DCH_F_PRATE 5
`define DCH_F_SRATE 7
`define DCH_F_SRANGE 8
`define DCH_F_SRC 9
`define DCH_F_LEVEL 16
`define DCH_RST_CTRL 32'h0000_0000
`define DCH_RST_GAIN 16'h0001
`define DCH_RST_OFFSET 32'h0000_0000
`define DCH_RST_UNIT 32'h0000_0000
`define DCH_PCT_FULL 7'h64
`define DCH_PWM_STEPS 12'h064
`define DCH_PWM_STEP_US_100HZ 100
`define DCH_PWM_STEP_US_10HZ 1000
`define DCH_PWM_STEP_US_1HZ 10000
`define DCH_PWM_STEP_US_0HZ1 100000
`define DCH_SRV_TICK_US 10
`define DCH_SRV_PER_US_50HZ 20000
`define DCH_SRV_PER_US_100HZ 10000
`define DCH_SRV_NARROW_MIN_US 1000
`define DCH_SRV_NARROW_SPAN_US 1000
`define DCH_SRV_WIDE_MIN_US 500
`define DCH_SRV_WIDE_SPAN_US 2000
`define DCH_SETTLE_US 50
`endif

// ---- hdl/dch_pkg.sv ----
// Types shared by the discrete channel block.
package dch_pkg;
   typedef enum logic [1:0] {
      DCH_IN_DIS = 2'h0,
      DCH_IN_HIGH = 2'h1,
      DCH_IN_LOW = 2'h2
   } dch_inpol_e;
   typedef enum logic [1:0] {
      DCH_OT_ONOFF = 2'h0,
      DCH_OT_PWM = 2'h1,
      DCH_OT_SERVO = 2'h2
   } dch_otype_e;
   typedef enum logic [1:0] {
      DCH_SRC_MAP = 2'h0,
      DCH_SRC_SETPT = 2'h1,
      DCH_SRC_ALARM = 2'h2
   } dch_src_e;
   typedef enum logic [1:0] {
      DCH_SM_IDLE = 2'b01,
      DCH_SM_SETTLE = 2'b10
   } dch_samp_e;
   typedef struct packed {
      dch_inpol_e in_pol;
      logic out_high;
      dch_otype_e otype;
      logic [1:0] prate;
      logic srate;
      logic srange;
      dch_src_e src;
      logic [6:0] level;
   } dch_chan_cfg_s;
   typedef struct packed {
      logic [11:0] paddr;
      logic psel;
      logic penable;
      logic pwrite;
      logic [31:0] pwdata;
   } dch_apb_req_s;
   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } dch_apb_rsp_s;
   typedef struct packed {
      dch_chan_cfg_s [1:0] cfg;
      logic scale_en;
      logic unit_lock;
      logic [15:0] gain;
      logic [31:0] offset;
      logic [31:0] unit;
      dch_samp_e samp;
      logic [15:0] settle;
      logic [1:0] in_act;
      logic [1:0][15:0] pcount;
      logic [1:0][21:0] pre;
      logic [1:0][11:0] step;
      logic [1:0][21:0] cur_pre;
      logic [1:0][11:0] cur_per;
      logic [1:0][11:0] cur_on;
      logic [1:0] cur_high;
      logic [1:0] cur_pulse;
      logic [1:0] act;
      logic [1:0] pin_oe;
      logic [31:0] rdata;
   } dch_state_s;
endpackage

// ---- hdl/dch_discrete_io.sv ----
// Two discrete channels: sensed inputs or open-drain ON/OFF, PWM and servo outputs, APB registers.
// Behaviour
// - Two independent channels, each usable as input or output.
// - Input polarity is active high, active low, or disabled to free the output.
// - Asserted output control turns the driver on, pulling the pin low.
// - Pull-up bias is enabled only while a reading is taken, then pin is sampled.
// - Input use needs output polarity active low, the reset default.
// - Output works only while that channel's input is disabled.
// - Active-high output conducts when inactive, floats when active.
// - Active-low output floats when inactive, conducts when active.
// - Output type is ON/OFF, PWM or servo.
// - ON/OFF type holds a static state, pin level per polarity.
// - PWM rate is 100 Hz, 10 Hz, 1 Hz or 0.1 Hz.
// - PWM active share equals programmed duty, 0 to 100 percent.
// - Servo on-time spans 1.0-2.0 ms or 0.5-2.5 ms, 0 to 180 degrees.
// - Servo repetition rate is 50 Hz or 100 Hz.
// - Servo uses active-high polarity from its second period on; its first period after ON/OFF keeps the programmed polarity.
// - Servo on-time is linear in commanded percent of travel.
// - Each output has one source: mapping, setpoint control or alarm.
// - Scaled value is raw reading times signed gain plus signed offset.
// - Display unit holds four characters and changes no measurement.
// - Setpoint ON gives 100 percent duty or full servo travel.
`timescale 1ns/1ns
`include "dch_cfg.svh"
module dch_discrete_io #(
   parameter int P_STEP_CYC_100HZ = `DCH_US_CYC(`DCH_PWM_STEP_US_100HZ),
   parameter int P_STEP_CYC_10HZ = `DCH_US_CYC(`DCH_PWM_STEP_US_10HZ),
   parameter int P_STEP_CYC_1HZ = `DCH_US_CYC(`DCH_PWM_STEP_US_1HZ),
   parameter int P_STEP_CYC_0HZ1 = `DCH_US_CYC(`DCH_PWM_STEP_US_0HZ1)
) (
   input wire logic i_core_clk,
   input wire logic i_resetn,
   input wire logic i_ce,
   input wire logic [11:0] i_paddr,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   input wire logic [1:0] i_setpoint_on,
   input wire logic [1:0] i_alarm_on,
   input wire logic [1:0] i_pin_in,
   output logic [1:0] o_pin_out,
   output logic [1:0] o_pin_oe,
   output logic [1:0] o_bias_en
);
   localparam logic [21:0] SRV_TICK = 22'(`DCH_US_CYC(`DCH_SRV_TICK_US));
   localparam logic [11:0] SRV_PER50 = 12'(`DCH_SRV_PER_US_50HZ / `DCH_SRV_TICK_US);
   localparam logic [11:0] SRV_PER100 = 12'(`DCH_SRV_PER_US_100HZ / `DCH_SRV_TICK_US);
   localparam logic [15:0] SRV_NMIN = 16'(`DCH_SRV_NARROW_MIN_US / `DCH_SRV_TICK_US);
   localparam logic [15:0] SRV_NSPAN = 16'(`DCH_SRV_NARROW_SPAN_US / `DCH_SRV_TICK_US);
   localparam logic [15:0] SRV_WMIN = 16'(`DCH_SRV_WIDE_MIN_US / `DCH_SRV_TICK_US);
   localparam logic [15:0] SRV_WSPAN = 16'(`DCH_SRV_WIDE_SPAN_US / `DCH_SRV_TICK_US);
   localparam logic [15:0] SETTLE_CYC = 16'(`DCH_US_CYC(`DCH_SETTLE_US));

   dch_pkg::dch_state_s st;
   dch_pkg::dch_state_s next_st;
   dch_pkg::dch_apb_req_s req;
   dch_pkg::dch_apb_rsp_s rsp;
   logic [1:0] in_en;
   logic [1:0] out_en;
   logic [1:0][31:0] value;

   assign req = '{paddr: i_paddr, psel: i_psel, penable: i_penable, pwrite: i_pwrite,
      pwdata: i_pwdata};

   function automatic logic [31:0] ctrl_rd(input dch_pkg::dch_chan_cfg_s c);
      logic [31:0] r;
      r = 32'h0000_0000;
      r[`DCH_F_INPOL +: 2] = c.in_pol;
      r[`DCH_F_OUTHIGH] = c.out_high;
      r[`DCH_F_OTYPE +: 2] = c.otype;
      r[`DCH_F_PRATE +: 2] = c.prate;
      r[`DCH_F_SRATE] = c.srate;
      r[`DCH_F_SRANGE] = c.srange;
      r[`DCH_F_SRC +: 2] = c.src;
      r[`DCH_F_LEVEL +: 7] = c.level;
      return r;
   endfunction

   function automatic dch_pkg::dch_chan_cfg_s ctrl_wr(input logic [31:0] d);
      dch_pkg::dch_chan_cfg_s c;
      c.in_pol = dch_pkg::dch_inpol_e'(d[`DCH_F_INPOL +: 2]);
      c.out_high = d[`DCH_F_OUTHIGH];
      c.otype = dch_pkg::dch_otype_e'(d[`DCH_F_OTYPE +: 2]);
      c.prate = d[`DCH_F_PRATE +: 2];
      c.srate = d[`DCH_F_SRATE];
      c.srange = d[`DCH_F_SRANGE];
      c.src = dch_pkg::dch_src_e'(d[`DCH_F_SRC +: 2]);
      c.level = d[`DCH_F_LEVEL +: 7];
      return c;
   endfunction

   // Address decode used only by the error flag; one entry per mapped register word.
   function automatic logic addr_mapped(input logic [11:0] a);
      logic m;
      m = 1'b1;
      if (a == `DCH_OFF_CTRL0) begin
         m = 1'b1;
      end else if (a == `DCH_OFF_CTRL1) begin
         m = 1'b1;
      end else if (a == `DCH_OFF_STATUS) begin
         m = 1'b1;
      end else if (a == `DCH_OFF_SAMPLE) begin
         m = 1'b1;
      end else if (a == `DCH_OFF_SCALE) begin
         m = 1'b1;
      end else if (a == `DCH_OFF_GAIN) begin
         m = 1'b1;
      end else if (a == `DCH_OFF_OFFSET) begin
         m = 1'b1;
      end else if (a == `DCH_OFF_UNIT) begin
         m = 1'b1;
      end else if (a == `DCH_OFF_VALUE0) begin
         m = 1'b1;
      end else if (a == `DCH_OFF_VALUE1) begin
         m = 1'b1;
      end else begin
         m = 1'b0;
      end
      return m;
   endfunction

   // Scaling rule applied to the sensed pulse count.
   // Both operands are widened to 32 bits first, so the product keeps the sign of the gain
   // whatever width rules a tool applies inside a cast.
   // The sum wraps at 32 bits; software must keep gain and offset in a sensible range.
   always_comb begin
      for (int i = 0; i < 2; i++) begin
         if (st.scale_en) begin
            value[i] = ($signed({16'h0000, st.pcount[i]})
               * $signed({{16{st.gain[15]}}, st.gain}))
               + st.offset;
         end else begin
            value[i] = {16'h0000, st.pcount[i]};
         end
      end
   end

   always_comb begin
      logic setup;
      logic wr;
      logic hit;
      logic [31:0] rd;
      logic [6:0] pct;
      logic [15:0] son;
      logic [21:0] npre;
      logic [11:0] nper;
      logic [11:0] non;
      logic boundary;
      logic onoff_act;
      logic live_act;
      setup = 1'b0;
      wr = 1'b0;
      hit = 1'b1;
      rd = 32'h0000_0000;
      pct = 7'h00;
      son = 16'h0000;
      npre = 22'h00_0000;
      nper = 12'h000;
      non = 12'h000;
      boundary = 1'b0;
      onoff_act = 1'b0;
      live_act = 1'b0;
      next_st = st;
      in_en = 2'b00;
      out_en = 2'b00;

      setup = req.psel && !req.penable;
      wr = req.psel && req.penable && req.pwrite;
      if (req.paddr == `DCH_OFF_CTRL0) begin
         rd = ctrl_rd(st.cfg[0]);
      end else if (req.paddr == `DCH_OFF_CTRL1) begin
         rd = ctrl_rd(st.cfg[1]);
      end else if (req.paddr == `DCH_OFF_STATUS) begin
         rd = {27'h000_0000, st.samp == dch_pkg::DCH_SM_SETTLE, st.act, st.in_act};
      end else if (req.paddr == `DCH_OFF_SAMPLE) begin
         rd = 32'h0000_0000;
      end else if (req.paddr == `DCH_OFF_SCALE) begin
         rd = {30'h0000_0000, st.unit_lock, st.scale_en};
      end else if (req.paddr == `DCH_OFF_GAIN) begin
         rd = {16'h0000, st.gain};
      end else if (req.paddr == `DCH_OFF_OFFSET) begin
         rd = st.offset;
      end else if (req.paddr == `DCH_OFF_UNIT) begin
         rd = st.unit;
      end else if (req.paddr == `DCH_OFF_VALUE0) begin
         rd = value[0];
      end else if (req.paddr == `DCH_OFF_VALUE1) begin
         rd = value[1];
      end else begin
         hit = 1'b0;
      end
      // Read data is captured in the setup cycle so the access phase can finish at once.
      if (setup) begin
         next_st.rdata = rd;
      end
      if (wr && hit) begin
         if (req.paddr == `DCH_OFF_CTRL0) begin
            next_st.cfg[0] = ctrl_wr(req.pwdata);
         end else if (req.paddr == `DCH_OFF_CTRL1) begin
            next_st.cfg[1] = ctrl_wr(req.pwdata);
         end else if (req.paddr == `DCH_OFF_SCALE) begin
            next_st.scale_en = req.pwdata[0];
            next_st.unit_lock = req.pwdata[1];
         end else if (req.paddr == `DCH_OFF_GAIN) begin
            next_st.gain = req.pwdata[15:0];
         end else if (req.paddr == `DCH_OFF_OFFSET) begin
            next_st.offset = req.pwdata;
         end else if (req.paddr == `DCH_OFF_UNIT) begin
            // Unit text is stored only; measurement path never reads it.
            next_st.unit = req.pwdata;
         end
      end

      for (int i = 0; i < 2; i++) begin
         // Disabled input frees the channel for output.
         out_en[i] = st.cfg[i].in_pol == dch_pkg::DCH_IN_DIS;
         in_en[i] = !out_en[i] && !st.cfg[i].out_high;
      end

      // Bias is held only for the settle window of a requested reading.
      // The pin is sampled on the last settle edge, while the pull-up still stands, so a
      // floating contact reads as high and never as a stale level.
      // A second sample request during a reading is dropped rather than queued.
      case (st.samp)
         dch_pkg::DCH_SM_IDLE: begin
            if (wr && req.paddr == `DCH_OFF_SAMPLE) begin
               next_st.samp = dch_pkg::DCH_SM_SETTLE;
               next_st.settle = 16'h0000;
            end
         end
         dch_pkg::DCH_SM_SETTLE: begin
            next_st.settle = st.settle + 16'h0001;
            if (st.settle + 16'h0001 >= SETTLE_CYC) begin
               next_st.samp = dch_pkg::DCH_SM_IDLE;
               for (int i = 0; i < 2; i++) begin
                  if (in_en[i]) begin
                     // Polarity decides which level counts as active.
                     next_st.in_act[i] = st.cfg[i].in_pol == dch_pkg::DCH_IN_HIGH ?
                        i_pin_in[i] : !i_pin_in[i];
                     if (next_st.in_act[i] && !st.in_act[i]) begin
                        next_st.pcount[i] = st.pcount[i] + 16'h0001;
                     end
                  end else begin
                     next_st.in_act[i] = 1'b0;
                  end
               end
            end
         end
         default: begin
            next_st.samp = dch_pkg::DCH_SM_IDLE;
         end
      endcase

      for (int i = 0; i < 2; i++) begin
         // Exactly one source feeds the commanded percentage.
         // Setpoint or alarm ON means full duty or full travel.
         if (st.cfg[i].src == dch_pkg::DCH_SRC_SETPT) begin
            pct = i_setpoint_on[i] ? `DCH_PCT_FULL : 7'h00;
         end else if (st.cfg[i].src == dch_pkg::DCH_SRC_ALARM) begin
            pct = i_alarm_on[i] ? `DCH_PCT_FULL : 7'h00;
         end else begin
            pct = st.cfg[i].level > `DCH_PCT_FULL ? `DCH_PCT_FULL : st.cfg[i].level;
         end
         // Period and on-time are chosen by the output type.
         if (st.cfg[i].otype == dch_pkg::DCH_OT_SERVO) begin
            npre = SRV_TICK;
            // Servo repetition 50 Hz or 100 Hz.
            nper = st.cfg[i].srate ? SRV_PER100 : SRV_PER50;
            // Range picks the minimum and span of the pulse.
            // Pulse grows linearly with percent of travel.
            if (st.cfg[i].srange) begin
               son = SRV_WMIN + 16'((32'(pct) * 32'(SRV_WSPAN)) / 32'(`DCH_PCT_FULL));
            end else begin
               son = SRV_NMIN + 16'((32'(pct) * 32'(SRV_NSPAN)) / 32'(`DCH_PCT_FULL));
            end
            non = son[11:0];
         end else begin
            // Four PWM rates, each a hundred steps long.
            case (st.cfg[i].prate)
               2'h0: npre = 22'(P_STEP_CYC_100HZ);
               2'h1: npre = 22'(P_STEP_CYC_10HZ);
               2'h2: npre = 22'(P_STEP_CYC_1HZ);
               default: npre = 22'(P_STEP_CYC_0HZ1);
            endcase
            nper = `DCH_PWM_STEPS;
            // Active steps equal the duty percentage.
            non = {5'h00, pct};
         end
         next_st.pre[i] = st.pre[i] + 22'h00_0001;
         if (st.pre[i] + 22'h00_0001 >= st.cur_pre[i]) begin
            next_st.pre[i] = 22'h00_0000;
            next_st.step[i] = st.step[i] + 12'h001;
            boundary = st.step[i] + 12'h001 >= st.cur_per[i];
         end else begin
            boundary = 1'b0;
         end
         // New timing is taken only when a period ends.
         // This costs up to one slow period of latency, but never cuts a pulse short.
         // After reset the period registers are zero, so the first boundary comes at once.
         if (boundary) begin
            next_st.step[i] = 12'h000;
            next_st.cur_pre[i] = npre;
            next_st.cur_per[i] = nper;
            next_st.cur_on[i] = non;
            next_st.cur_pulse[i] = st.cfg[i].otype != dch_pkg::DCH_OT_ONOFF;
            next_st.cur_high[i] = st.cfg[i].otype == dch_pkg::DCH_OT_SERVO ? 1'b1 :
               st.cfg[i].out_high;
         end
         // ON/OFF follows its command at once with the live polarity.
         onoff_act = pct != 7'h00;
         // Step below zero never matches; full count covers every step.
         live_act = st.cur_pulse[i] ? st.step[i] < st.cur_on[i] : onoff_act;
         // Output function only with input disabled.
         next_st.act[i] = out_en[i] && live_act;
         if (!st.cur_pulse[i]) begin
            next_st.cur_high[i] = st.cfg[i].out_high;
         end
         // Driver released whenever the channel senses.
         next_st.pin_oe[i] = out_en[i] && (st.cur_high[i] ? !live_act : live_act);
      end
   end

   // One state record clocks both channels.
   // A low clock enable freezes bus writes, sampling and the period counters alike.
   always_ff @(posedge i_core_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         st <= '0;
         st.cfg <= {2{dch_pkg::dch_chan_cfg_s'(`DCH_RST_CTRL)}};
         st.gain <= `DCH_RST_GAIN;
         st.offset <= `DCH_RST_OFFSET;
         st.unit <= `DCH_RST_UNIT;
         st.samp <= dch_pkg::DCH_SM_IDLE;
      end else if (i_ce) begin
         st <= next_st;
      end
   end

   always_comb begin
      rsp.prdata = st.rdata;
      rsp.pready = 1'b1;
      rsp.pslverr = 1'b0;
      // The slave never stalls, so the error flag only needs the access phase and the decode.
      if (req.psel && req.penable && !addr_mapped(req.paddr)) begin
         rsp.pslverr = 1'b1;
      end
   end

   // The data pin is fixed low; only the enable moves, as an open-drain stage needs.

   assign o_prdata = rsp.prdata;
   assign o_pready = rsp.pready;
   assign o_pslverr = rsp.pslverr;
   // An enabled driver always pulls the pin low.
   assign o_pin_out = 2'b00;
   assign o_pin_oe = st.pin_oe;
   assign o_bias_en = st.samp == dch_pkg::DCH_SM_SETTLE ? in_en : 2'b00;
endmodule

// ---- tb/dch_io_assertions.sv ----
// Port-level concurrent checks for the discrete channel block.
`timescale 1ns/1ns
module dch_io_assertions (
   input wire logic i_core_clk,
   input wire logic i_resetn,
   input wire logic i_ce,
   input wire logic [11:0] i_paddr,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [31:0] o_prdata,
   input wire logic o_pready,
   input wire logic o_pslverr,
   input wire logic [1:0] o_pin_out,
   input wire logic [1:0] o_pin_oe,
   input wire logic [1:0] o_bias_en
);
   logic [15:0] bias_cnt;
   logic bias_any;
   logic sample_hit;
   assign bias_any = |o_bias_en;
   assign sample_hit = i_ce && i_psel && i_penable && i_pwrite && (i_paddr == 12'h00C);
   // The reading window is 1000 cycles, far beyond a plain delay, so it is counted here.
   always_ff @(posedge i_core_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         bias_cnt <= 16'h0000;
      end else begin
         bias_cnt <= bias_any ? bias_cnt + 16'h0001 : 16'h0000;
      end
   end
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_resetn);
   sequence s_window;
      bias_any [*8];
   endsequence
   a_bias_start: assert property ($rose(bias_any) |-> $past(sample_hit))
      else $error("bias rose without a sample request");
   a_bias_hold: assert property ($rose(bias_any) |-> s_window)
      else $error("bias window broke early");
   a_bias_length: assert property ($fell(bias_any) |-> bias_cnt == 16'h03E8)
      else $error("bias window length wrong");
   a_bias_limit: assert property (bias_any |-> bias_cnt < 16'h03E8)
      else $error("bias held too long");
   a_bias_excl: assert property ((o_bias_en & o_pin_oe) == 2'h0)
      else $error("bias and driver on together");
   a_pin_float: assert property (o_pin_out == 2'h0)
      else $error("open-drain data not low");
   a_ready_now: assert property (i_psel && i_penable |-> o_pready)
      else $error("access phase not ready");
   a_slverr_map: assert property (i_psel && i_penable && i_paddr > 12'h024 |-> o_pslverr)
      else $error("unmapped access not flagged");
   a_slverr_quiet: assert property (!(i_psel && i_penable) |-> !o_pslverr)
      else $error("error flag outside access");
   a_rdata_stand: assert property (!(i_psel && !i_penable && i_ce) |=> $stable(o_prdata))
      else $error("read data moved outside setup");
   a_ce_freeze: assert property (!i_ce |=> $stable(o_pin_oe) && $stable(o_bias_en))
      else $error("outputs moved with clock enable low");
endmodule

// ---- tb/dch_load_model.sv ----
// Load, contact and bias pull-up seen on the two discrete channel pins.
`timescale 1ns/1ns
module dch_load_model (
   input wire logic i_core_clk,
   input wire logic [1:0] i_pin_oe,
   input wire logic [1:0] i_bias_en,
   input wire logic [1:0] i_contact,
   output logic [1:0] o_pin
);
   logic [1:0] drift = 2'h1;
   // An unbiased, undriven pin floats, so it must not look like a stable level.
   always @(posedge i_core_clk) drift <= ~drift;
   always_comb begin
      for (int i = 0; i < 2; i++) begin
         o_pin[i] = (i_pin_oe[i] || i_contact[i]) ? 1'b0 : (i_bias_en[i] ? 1'b1 : drift[i]);
      end
   end
endmodule

// ---- tb/dch_discrete_io_test.sv ----
// Self-checking bench for the discrete channel block.
`timescale 1ns/1ns
`include "dch_cfg.svh"
module dch_discrete_io_test;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic ce = 1'b1;
   logic [11:0] paddr = 12'h000;
   logic psel = 1'b0;
   logic pen = 1'b0;
   logic pwr = 1'b0;
   logic [31:0] pwd = 32'h0000_0000;
   logic [31:0] prd;
   logic prdy;
   logic perr;
   logic [1:0] spt = 2'h0;
   logic [1:0] alm = 2'h0;
   logic [1:0] contact = 2'h0;
   logic [1:0] pin;
   logic [1:0] oe;
   logic [1:0] bias;
   int errors = 0;
   int compares = 0;
   logic [15:0] seed = 16'h000F;
   logic [31:0] rd;
   logic err;
   logic [31:0] ofs;
   logic [31:0] scaled;
   logic [11:0] ra [8] = '{12'h000, 12'h004, 12'h008, 12'h010, 12'h014, 12'h018, 12'h01C,
      12'h020};
   always #25 clk = ~clk;
   dch_discrete_io #(.P_STEP_CYC_100HZ(4), .P_STEP_CYC_10HZ(8), .P_STEP_CYC_1HZ(16),
      .P_STEP_CYC_0HZ1(32)) dut (.i_core_clk(clk), .i_resetn(rstn), .i_ce(ce),
      .i_paddr(paddr), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_pwdata(pwd),
      .o_prdata(prd), .o_pready(prdy), .o_pslverr(perr), .i_setpoint_on(spt),
      .i_alarm_on(alm), .i_pin_in(pin), .o_pin_out(), .o_pin_oe(oe), .o_bias_en(bias));
   dch_load_model load (.i_core_clk(clk), .i_pin_oe(oe), .i_bias_en(bias),
      .i_contact(contact), .o_pin(pin));
   task automatic print_verdict();
      if (errors == 0 && compares > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      pen <= 1'b0;
      paddr <= a;
      pwr <= wr;
      pwd <= d;
      @(posedge clk);
      pen <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (prdy !== 1'b1 && n < 16);
      if (n == 16) begin
         errors++;
         print_verdict();
      end
      rd = prd;
      err = perr;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask
   task automatic sample(input logic [1:0] eb, input logic [31:0] est);
      int n;
      apb(1'b1, `DCH_OFF_SAMPLE, 32'h0000_0000);
      @(posedge clk);
      chk("bias", {30'h0, eb}, {30'h0, bias});
      for (n = 0; n < 1100 && bias !== 2'h0; n++) begin
         @(posedge clk);
      end
      if (n == 1100) begin
         errors++;
         print_verdict();
      end
      apb(1'b0, `DCH_OFF_STATUS, 32'h0000_0000);
      chk("status", est, rd & 32'h0000_0013);
   endtask
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   // Expected driver-on cycles in one period; active-high floats while active.
   function automatic int pwm_exp(input int d, input int oh, input int sp, input int st);
      int on;
      on = sp ? 100 : ((d > 100) ? 100 : d);
      return (oh ? 100 - on : on) * st;
   endfunction
   initial begin
      cyc(100000);
      errors++;
      print_verdict();
   end
   initial begin
      int prev;
      int st;
      int d;
      int oh;
      int sp;
      int cnt;
      logic [31:0] ctl;
      cyc(5);
      rstn <= 1'b1;
      foreach (ra[i]) begin
         apb(1'b0, ra[i], 32'h0000_0000);
         chk("reset value", (ra[i] == `DCH_OFF_GAIN) ? 32'h0000_0001 : 32'h0000_0000, rd);
      end
      apb(1'b1, 12'h028, 32'h0000_00FF);
      chk("slverr", 32'h0000_0001, {31'h0, err});
      apb(1'b0, 12'hFFC, 32'h0000_0000);
      chk("slverr", 32'h0000_0001, {31'h0, err});
      apb(1'b1, `DCH_OFF_STATUS, 32'hFFFF_FFFF);
      apb(1'b0, `DCH_OFF_STATUS, 32'h0000_0000);
      chk("status ro", 32'h0000_0000, rd);
      repeat (3) begin
         seed = lfsr(seed);
         ofs = {seed, lfsr(seed)};
         apb(1'b1, `DCH_OFF_GAIN, ofs);
         apb(1'b1, `DCH_OFF_OFFSET, ofs);
         apb(1'b1, `DCH_OFF_UNIT, ofs);
         apb(1'b0, `DCH_OFF_GAIN, 32'h0000_0000);
         chk("gain", {16'h0000, ofs[15:0]}, rd);
         apb(1'b0, `DCH_OFF_OFFSET, 32'h0000_0000);
         chk("offset", ofs, rd);
         apb(1'b0, `DCH_OFF_UNIT, 32'h0000_0000);
         chk("unit", ofs, rd);
      end
      @(posedge clk);
      ce <= 1'b0;
      apb(1'b1, `DCH_OFF_CTRL0, 32'h0000_0004);
      @(posedge clk);
      ce <= 1'b1;
      apb(1'b0, `DCH_OFF_CTRL0, 32'h0000_0000);
      chk("frozen ctrl", 32'h0000_0000, rd);
      for (int k = 0; k < 8; k++) begin
         ctl = {21'h0, k[2], ~k[2], 6'h00, k[1], 2'h0};
         apb(1'b1, `DCH_OFF_CTRL0, ctl);
         apb(1'b1, `DCH_OFF_CTRL1, ctl);
         spt <= k[2] ? ~{2{k[0]}} : {2{k[0]}};
         alm <= k[2] ? {2{k[0]}} : ~{2{k[0]}};
         cyc(3);
         chk("onoff oe", {30'h0, {2{k[0] ^ k[1]}}}, {30'h0, oe});
      end
      spt <= 2'h3;
      contact <= 2'h1;
      apb(1'b1, `DCH_OFF_CTRL0, 32'h0000_0202);
      apb(1'b1, `DCH_OFF_CTRL1, 32'h0000_0005);
      apb(1'b1, `DCH_OFF_SCALE, 32'h0000_0001);
      cyc(2);
      chk("input owns pin", 32'h0000_0000, {30'h0, oe});
      sample(2'h1, 32'h0000_0001);
      scaled = {{16{ofs[15]}}, ofs[15:0]} + ofs;
      apb(1'b0, `DCH_OFF_VALUE0, 32'h0000_0000);
      chk("value0", scaled, rd);
      contact <= 2'h0;
      apb(1'b1, `DCH_OFF_CTRL1, 32'h0000_0001);
      sample(2'h3, 32'h0000_0002);
      apb(1'b0, `DCH_OFF_VALUE1, 32'h0000_0000);
      chk("value1", scaled, rd);
      apb(1'b1, `DCH_OFF_CTRL1, 32'h0000_0000);
      prev = 400;
      for (int k = 0; k < 9; k++) begin
         seed = lfsr(seed);
         d = (k < 5) ? ((k == 3) ? 25 : ((k == 2) ? 120 : k * 75)) : int'(seed % 16'h0065);
         oh = (k == 3) ? 1 : 0;
         sp = (k == 4) ? 1 : 0;
         st = 4 << ((k < 5) ? 0 : k - 5);
         ctl = (d << 16) | (sp << 9) | (((k < 5) ? 0 : k - 5) << 5) | 32'h0000_0008 | (oh << 2);
         apb(1'b1, `DCH_OFF_CTRL0, ctl);
         cyc(prev + 100 * st + 4);
         cnt = 0;
         repeat (100 * st) begin
            @(posedge clk);
            cnt += int'(oe[0]);
         end
         chk("pwm on count", pwm_exp(d, oh, sp, st), cnt);
         prev = 100 * st;
      end
      print_verdict();
   end
endmodule
bind dch_discrete_io dch_io_assertions u_chk (.i_core_clk(i_core_clk), .i_resetn(i_resetn),
   .i_ce(i_ce), .i_paddr(i_paddr), .i_psel(i_psel), .i_penable(i_penable),
   .i_pwrite(i_pwrite), .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
   .o_pin_out(o_pin_out), .o_pin_oe(o_pin_oe), .o_bias_en(o_bias_en));
